// ---- hpp_host_model.sv ----
// Host master model: framed serial master and microport host
module hpp_host_model (
  // Clock used to catch short ready pulses
  input  wire logic        mclk,
  // Serial master pins
  output logic             serial_clk,
  output logic             serial_chip_select_n,
  output logic             serial_in,
  output logic             receive_frame_pulse,
  output logic             transmit_frame_pulse,
  input  wire logic        serial_out_o,
  input  wire logic        serial_out_oe_n,
  // Microport host pins
  output logic             host_port_clock,
  output logic             chip_select_n,
  output logic      [7:0]  addr,
  output logic      [15:0] data_i,
  output logic             wr_n_rw,
  output logic             rd_n_ds_n,
  input  wire logic [15:0] data_o,
  input  wire logic        data_oe_n,
  input  wire logic        ready_o,
  input  wire logic        ready_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  int          tmo = 0;
  // Open-drain lines rest high through their pull-ups; the bus floats
  wire         sdo_w = serial_out_oe_n ? 1'b1 : serial_out_o;
  wire         rdy_w = ready_oe_n ? 1'b1 : ready_o;
  wire  [15:0] bus_w = data_oe_n ? 16'hZZZZ : data_o;

  // Serial clock never stops, phase unrelated to mclk
  initial begin
    {serial_clk, serial_in, receive_frame_pulse, transmit_frame_pulse} = 4'h0;
    {serial_chip_select_n, chip_select_n, wr_n_rw, rd_n_ds_n} = 4'hF;
    host_port_clock = 1'b0;
    addr = 8'h00;
    data_i = 16'h0000;
    #37;
    forever #80 serial_clk = ~serial_clk;
  end
  // Host clock at 25 MHz, well below mclk; offset so no edge meets an mclk edge
  initial begin
    #2;
    forever #20 host_port_clock = ~host_port_clock;
  end

  task automatic sel(input logic v);
    @(negedge serial_clk) serial_chip_select_n <= v;
  endtask

  // Written byte: frame pulse clock, eight data clocks, then the line drifts
  task automatic put_byte(input logic [7:0] b, input logic msb);
    @(negedge serial_clk) receive_frame_pulse <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(negedge serial_clk) receive_frame_pulse <= 1'b0;
      serial_in <= b[msb ? 7 - i : i];
    end
    @(negedge serial_clk) serial_in <= ~serial_in;
  endtask

  // Read byte: transmit pulse, bits caught on falling edges
  task automatic get_byte(input logic msb, output logic [7:0] b);
    @(negedge serial_clk) transmit_frame_pulse <= 1'b1;
    @(negedge serial_clk) transmit_frame_pulse <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(negedge serial_clk) b[msb ? 7 - i : i] = sdo_w;
    end
  endtask

  // One access; everything held until the handshake edge
  task automatic mp(input logic md, input logic rd, input logic [7:0] a,
                    input logic [15:0] d, output logic [15:0] q);
    int k;
    @(posedge host_port_clock) #1;
    k = 0;
    addr = a;
    data_i = rd ? ~d : d; // Read: host bus let go, junk shown
    wr_n_rw = rd;
    rd_n_ds_n = md ? 1'b0 : ~rd;
    @(posedge host_port_clock) #1 chip_select_n = 1'b0;
    // An 8-bit split ready pulse is shorter than a host clock, so watch it on mclk
    while (!md && rdy_w && k < 100) begin
      @(posedge mclk);
      k++;
    end
    do begin
      @(posedge host_port_clock);
      k++;
    end while (rdy_w === md && k < 150);
    q = bus_w;
    if (k >= 100) tmo++;
    #1 {chip_select_n, wr_n_rw, rd_n_ds_n} = 3'h7;
    repeat (3) @(posedge host_port_clock);
  endtask
endmodule // hpp_host_model

// ---- hpp_pkg.sv ----
// Package of constants for the host programming port
package hpp_pkg;
  // Field positions and widths
  localparam int          ADDR_W       = 8;
  localparam int          BYTE_W       = 8;
  localparam int          DATA_W       = 16;
  localparam int          DIR_BIT      = 7;
  localparam int          CNT_W        = 7;
  localparam int          BITCNT_W     = 4;
  // Bits per byte, as a counter value
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  // Register file depth in byte locations
  localparam int          MEM_DEPTH    = 256;
  // Microport internal access latency in mclk cycles
  localparam logic [2:0]  ACC_CYCLES   = 3'h3;
  // Reset values
  localparam logic [7:0]  BYTE_RST     = 8'h00;
  localparam logic [6:0]  CNT_RST      = 7'h00;
  localparam logic [3:0]  BITCNT_RST   = 4'h0;
  localparam logic [2:0]  ACC_RST      = 3'h0;

  // Framed serial states
  typedef enum logic [4:0] {
    HPP_S_IDLE  = 5'b00001,
    HPP_S_ADDR  = 5'b00010,
    HPP_S_CMD   = 5'b00100,
    HPP_S_WDATA = 5'b01000,
    HPP_S_RDATA = 5'b10000
  } hpp_ser_e;

  // Microport states
  typedef enum logic [3:0] {
    HPP_M_IDLE = 4'b0001,
    HPP_M_BUSY = 4'b0010,
    HPP_M_DONE = 4'b0100,
    HPP_M_WAIT = 4'b1000
  } hpp_mp_e;
endpackage

// ---- hpp_port.sv ----
// Host programming port: framed serial and parallel microport front end
module hpp_port (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // Static selection pins
  input  wire logic        port_select,
  input  wire logic        mode_pin,
  input  wire logic        bit_order_select,
  input  wire logic        bus_width_16,
  // Framed serial pins
  input  wire logic        serial_clk,
  input  wire logic        serial_chip_select_n,
  input  wire logic        serial_in,
  input  wire logic        receive_frame_pulse,
  input  wire logic        transmit_frame_pulse,
  output logic             serial_out_o,
  output logic             serial_out_oe_n,
  // Microport pins
  input  wire logic        host_port_clock,
  input  wire logic        chip_select_n,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] data_i,
  output logic      [15:0] data_o,
  output logic             data_oe_n,
  input  wire logic        wr_n_rw,
  input  wire logic        rd_n_ds_n,
  output logic             ready_o,
  output logic             ready_oe_n
);
  // Synchronised inputs
  logic [1:0] sclk_s, scs_s, sdi_s, rfs_s, tfs_s, cclk_s, cs_s, wr_s, rd_s;
  logic       sclk_d, cclk_d, sclk_rise, sclk_fall, cclk_rise;
  logic       ser_en, ser_rst, mp_en;

  // Two-stage synchronisers on every asynchronous pin
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sclk_s <= 2'h0;
      scs_s  <= 2'h3;
      sdi_s  <= 2'h0;
      rfs_s  <= 2'h0;
      tfs_s  <= 2'h0;
      cclk_s <= 2'h0;
      cs_s   <= 2'h3;
      wr_s   <= 2'h3;
      rd_s   <= 2'h3;
    end else begin
      sclk_s <= {sclk_s[0], serial_clk};
      scs_s  <= {scs_s[0], serial_chip_select_n};
      sdi_s  <= {sdi_s[0], serial_in};
      rfs_s  <= {rfs_s[0], receive_frame_pulse};
      tfs_s  <= {tfs_s[0], transmit_frame_pulse};
      cclk_s <= {cclk_s[0], host_port_clock};
      cs_s   <= {cs_s[0], chip_select_n};
      wr_s   <= {wr_s[0], wr_n_rw};
      rd_s   <= {rd_s[0], rd_n_ds_n};
    end
  end

  // Edge history of both link clocks
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sclk_d <= 1'b0;
      cclk_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s[1];
      cclk_d <= cclk_s[1];
    end
  end

  assign sclk_rise = sclk_s[1] & ~sclk_d;
  assign sclk_fall = ~sclk_s[1] & sclk_d;
  assign cclk_rise = cclk_s[1] & ~cclk_d;
  // SPI operation is outside this block, so serial logic runs only in framed mode
  assign ser_en  = port_select & mode_pin;
  assign mp_en   = ~port_select;
  assign ser_rst = ~ser_en | scs_s[1];

  // Framed serial engine
  hpp_pkg::hpp_ser_e ser_st_r;
  logic [7:0] sh_r, ser_addr_r, tx_r;
  logic [6:0] cnt_r;
  logic [3:0] bit_r, tbit_r;
  logic       in_byte_r, tx_act_r, tx_load_r, ser_we;
  logic [7:0] sh_nxt;

  // Insert the new bit at the end set by the bit order
  assign sh_nxt = bit_order_select ? {sh_r[6:0], sdi_s[1]}
                                   : {sdi_s[1], sh_r[7:1]};

  // Byte receiver: pulse, then eight rising-edge samples
  always_ff @(posedge mclk) begin
    if (!nrst || ser_rst) begin
      in_byte_r <= 1'b0;
      bit_r     <= hpp_pkg::BITCNT_RST;
      sh_r      <= hpp_pkg::BYTE_RST;
    end else if (sclk_rise) begin
      if (!in_byte_r && rfs_s[1] && ser_st_r != hpp_pkg::HPP_S_RDATA) begin
        in_byte_r <= 1'b1;
        bit_r     <= hpp_pkg::BITCNT_RST;
      end else if (in_byte_r) begin
        sh_r  <= sh_nxt;
        bit_r <= bit_r + 4'h1;
        if (bit_r == hpp_pkg::BITS_PER_BYTE - 4'h1) begin
          in_byte_r <= 1'b0;
        end
      end
    end
  end

  logic byte_done;
  assign byte_done = sclk_rise & in_byte_r & (bit_r == hpp_pkg::BITS_PER_BYTE - 4'h1);

  // Transfer sequencer
  always_ff @(posedge mclk) begin
    if (!nrst || ser_rst) begin
      ser_st_r   <= hpp_pkg::HPP_S_IDLE;
      ser_addr_r <= hpp_pkg::BYTE_RST;
      cnt_r      <= hpp_pkg::CNT_RST;
    end else begin
      case (ser_st_r)
        hpp_pkg::HPP_S_IDLE: begin
          if (byte_done) begin
            ser_addr_r <= sh_nxt;
            ser_st_r   <= hpp_pkg::HPP_S_CMD;
          end
        end
        hpp_pkg::HPP_S_CMD: begin
          if (byte_done) begin
            cnt_r <= sh_nxt[hpp_pkg::CNT_W-1:0];
            if (sh_nxt[hpp_pkg::CNT_W-1:0] == hpp_pkg::CNT_RST) begin
              ser_st_r <= hpp_pkg::HPP_S_IDLE;
            end else if (sh_nxt[hpp_pkg::DIR_BIT]) begin
              ser_st_r <= hpp_pkg::HPP_S_RDATA;
            end else begin
              ser_st_r <= hpp_pkg::HPP_S_WDATA;
            end
          end
        end
        hpp_pkg::HPP_S_WDATA: begin
          if (byte_done) begin
            ser_addr_r <= bit_order_select ? ser_addr_r - 8'h01
                                           : ser_addr_r + 8'h01;
            cnt_r      <= cnt_r - 7'h01;
            if (cnt_r == 7'h01) begin
              ser_st_r <= hpp_pkg::HPP_S_IDLE;
            end
          end
        end
        hpp_pkg::HPP_S_RDATA: begin
          if (tx_load_r) begin
            ser_addr_r <= bit_order_select ? ser_addr_r - 8'h01
                                           : ser_addr_r + 8'h01;
          end
          if (tx_act_r && sclk_rise && tbit_r == hpp_pkg::BITS_PER_BYTE - 4'h1) begin
            cnt_r <= cnt_r - 7'h01;
            if (cnt_r == 7'h01) begin
              ser_st_r <= hpp_pkg::HPP_S_IDLE;
            end
          end
        end
        default: ser_st_r <= hpp_pkg::HPP_S_IDLE;
      endcase
    end
  end

  assign ser_we = (ser_st_r == hpp_pkg::HPP_S_WDATA) & byte_done;

  // Transmitter: a transmit pulse starts eight bits shifted on rising edges
  logic [7:0] mem_rd_ser;
  always_ff @(posedge mclk) begin
    if (!nrst || ser_rst) begin
      tx_act_r  <= 1'b0;
      tx_load_r <= 1'b0;
      tbit_r    <= hpp_pkg::BITCNT_RST;
      tx_r      <= hpp_pkg::BYTE_RST;
      serial_out_o    <= 1'b1;
      serial_out_oe_n <= 1'b1;
    end else begin
      tx_load_r <= 1'b0;
      if (ser_st_r == hpp_pkg::HPP_S_RDATA && sclk_rise && tfs_s[1] && !tx_act_r) begin
        tx_act_r  <= 1'b1;
        tbit_r    <= hpp_pkg::BITCNT_RST;
        tx_r      <= mem_rd_ser;
        tx_load_r <= 1'b1;
      end else if (tx_act_r && sclk_rise) begin
        serial_out_o    <= bit_order_select ? tx_r[7] : tx_r[0];
        serial_out_oe_n <= 1'b0;
        tx_r   <= bit_order_select ? {tx_r[6:0], 1'b0} : {1'b0, tx_r[7:1]};
        tbit_r <= tbit_r + 4'h1;
        if (tbit_r == hpp_pkg::BITS_PER_BYTE - 4'h1) begin
          tx_act_r <= 1'b0;
        end
      end else if (!tx_act_r && sclk_fall) begin
        serial_out_oe_n <= 1'b1;
        serial_out_o    <= 1'b1;
      end
    end
  end

  // Microport engine
  hpp_pkg::hpp_mp_e mp_st_r;
  logic [2:0] acc_r;
  logic       mp_rd_r, hi_r, mp_we;
  logic [7:0] mp_addr_r, mp_waddr, mp_wdata, mem_rd_mp, mem_raddr_mp;
  logic       strobe, is_read;
  logic [7:0]  addr_s0, addr_s1;
  logic [15:0] din_s0, din_s1;

  // Address and write data come from the host side; they stand from before
  // chip select until release, so a plain two-stage copy is safe here
  always_ff @(posedge mclk) begin
    addr_s0 <= addr;
    addr_s1 <= addr_s0;
    din_s0  <= data_i;
    din_s1  <= din_s0;
  end

  // Strobe and direction per mode
  assign strobe  = mode_pin ? ~rd_s[1] : (~rd_s[1] | ~wr_s[1]);
  assign is_read = mode_pin ? wr_s[1] : ~rd_s[1];

  // Access sequencer; 16-bit accesses take a low then a high byte
  always_ff @(posedge mclk) begin
    if (!nrst || !mp_en) begin
      mp_st_r   <= hpp_pkg::HPP_M_IDLE;
      acc_r     <= hpp_pkg::ACC_RST;
      mp_rd_r   <= 1'b0;
      hi_r      <= 1'b0;
      mp_addr_r <= hpp_pkg::BYTE_RST;
      data_o    <= 16'h0000;
    end else begin
      case (mp_st_r)
        hpp_pkg::HPP_M_IDLE: begin
          if (cclk_rise && !cs_s[1] && strobe) begin
            mp_st_r   <= hpp_pkg::HPP_M_BUSY;
            mp_rd_r   <= is_read;
            mp_addr_r <= addr_s1;
            acc_r     <= hpp_pkg::ACC_RST;
            hi_r      <= 1'b0;
          end
        end
        hpp_pkg::HPP_M_BUSY: begin
          acc_r <= acc_r + 3'h1;
          if (acc_r == hpp_pkg::ACC_CYCLES - 3'h1) begin
            if (hi_r) begin
              data_o[15:8] <= mem_rd_mp;
            end else begin
              data_o[7:0] <= mem_rd_mp;
            end
            if (bus_width_16 && !hi_r) begin
              hi_r  <= 1'b1;
              acc_r <= hpp_pkg::ACC_RST;
            end else begin
              mp_st_r <= hpp_pkg::HPP_M_DONE;
            end
          end
        end
        hpp_pkg::HPP_M_DONE: begin
          if (cclk_rise) begin
            mp_st_r <= hpp_pkg::HPP_M_WAIT;
          end
        end
        hpp_pkg::HPP_M_WAIT: begin
          if (cs_s[1] || !strobe) begin
            mp_st_r <= hpp_pkg::HPP_M_IDLE;
          end
        end
        default: mp_st_r <= hpp_pkg::HPP_M_IDLE;
      endcase
    end
  end

  assign mem_raddr_mp = hi_r ? mp_addr_r + 8'h01 : mp_addr_r;
  assign mp_we    = (mp_st_r == hpp_pkg::HPP_M_BUSY) & ~mp_rd_r &
                    (acc_r == hpp_pkg::ACC_RST);
  assign mp_waddr = mem_raddr_mp;
  assign mp_wdata = hi_r ? din_s1[15:8] : din_s1[7:0];

  // Ready or acknowledge pin, open drain: low drive means output enabled
  logic busy, done;
  assign busy = (mp_st_r == hpp_pkg::HPP_M_BUSY);
  assign done = (mp_st_r == hpp_pkg::HPP_M_DONE) | (mp_st_r == hpp_pkg::HPP_M_WAIT);
  always_comb begin
    ready_o = 1'b0;
    if (!mp_en || cs_s[1]) begin
      ready_oe_n = 1'b1;
    end else if (mode_pin) begin
      ready_oe_n = ~done;
    end else begin
      ready_oe_n = ~busy;
    end
  end

  // Data bus only during a read with chip select low on the microport
  assign data_oe_n = ~(mp_en & ~cs_s[1] & mp_rd_r & done);

  hpp_regmem u_mem (
    .mclk    (mclk),
    .nrst    (nrst),
    .we      (ser_we | mp_we),
    .waddr   (ser_we ? ser_addr_r : mp_waddr),
    .wdata   (ser_we ? sh_nxt : mp_wdata),
    .raddr_a (ser_addr_r),
    .rdata_a (mem_rd_ser),
    .raddr_b (mem_raddr_mp),
    .rdata_b (mem_rd_mp)
  );
endmodule // hpp_port

// ---- hpp_port_monitor.sv ----
// Assertion checker bound to the host programming port
module hpp_port_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Selection pins
  input wire logic port_select,
  input wire logic mode_pin,
  input wire logic bus_width_16,
  // Serial pins
  input wire logic serial_chip_select_n,
  input wire logic serial_out_oe_n,
  // Microport pins
  input wire logic chip_select_n,
  input wire logic wr_n_rw,
  input wire logic rd_n_ds_n,
  input wire logic data_oe_n,
  input wire logic ready_oe_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // Six cycles cover the synchronizer delay on the slow pins
  chk_sdo_cs_off: assert property (serial_chip_select_n [*6] |-> serial_out_oe_n)
    else $error("serial output driven while deselected");
  chk_sdo_mode_off: assert property ((!mode_pin || !port_select) [*6] |-> serial_out_oe_n)
    else $error("serial output driven outside framed mode");
  chk_bus_serial_off: assert property (port_select |-> data_oe_n && ready_oe_n)
    else $error("microport pins driven in serial mode");
  chk_bus_read_only: assert property (!data_oe_n |-> wr_n_rw)
    else $error("data bus driven outside a read");
  chk_rdy_span_8: assert property (!mode_pin && !bus_width_16 && $fell(ready_oe_n)
    |-> !ready_oe_n [*3] ##1 ready_oe_n) else $error("ready low span wrong, 8-bit");
  chk_rdy_span_16: assert property (!mode_pin && bus_width_16 && $fell(ready_oe_n)
    |-> !ready_oe_n [*6] ##1 ready_oe_n) else $error("ready low span wrong, 16-bit");
  chk_ack_hold: assert property (mode_pin && !ready_oe_n && !chip_select_n && !rd_n_ds_n
    |=> !ready_oe_n) else $error("acknowledge dropped while access held");
  chk_ack_release: assert property (chip_select_n [*6] |-> ready_oe_n)
    else $error("ready or acknowledge low while deselected");
  chk_ack_data: assert property (mode_pin && !ready_oe_n && wr_n_rw && !chip_select_n
    |-> !data_oe_n) else $error("acknowledge without read data");
  chk_rdy_data: assert property (!mode_pin && $rose(ready_oe_n) && wr_n_rw && !chip_select_n
    |-> !data_oe_n) else $error("ready released without read data");
endmodule // hpp_port_monitor

bind hpp_port hpp_port_monitor u_mon (
  .mclk                 (mclk),
  .nrst                 (nrst),
  .port_select          (port_select),
  .mode_pin             (mode_pin),
  .bus_width_16         (bus_width_16),
  .serial_chip_select_n (serial_chip_select_n),
  .serial_out_oe_n      (serial_out_oe_n),
  .chip_select_n        (chip_select_n),
  .wr_n_rw              (wr_n_rw),
  .rd_n_ds_n            (rd_n_ds_n),
  .data_oe_n            (data_oe_n),
  .ready_oe_n           (ready_oe_n)
);

// ---- hpp_port_test.sv ----
// Self-checking bench for the host programming port
module hpp_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk, nrst, port_select, mode_pin, bit_order_select, bus_width_16;
  logic        serial_clk, serial_chip_select_n, serial_in, receive_frame_pulse;
  logic        transmit_frame_pulse, serial_out_o, serial_out_oe_n, host_port_clock;
  logic        chip_select_n, wr_n_rw, rd_n_ds_n, ready_o, ready_oe_n, data_oe_n;
  logic [7:0]  addr, a, b;
  logic [15:0] data_i, data_o, q;
  logic [7:0]  sd [3] = '{8'h1E, 8'h96, 8'hC4};
  int          err_total = 0;
  int          n_compared = 0;
  // Rows: split/single, 16-bit, read, address, write data or read value
  logic [26:0] rows [9] = '{
    {3'b000, 8'h20, 16'h005A}, {3'b101, 8'h20, 16'h005A}, {3'b110, 8'h30, 16'hC33C},
    {3'b011, 8'h30, 16'hC33C}, {3'b001, 8'h31, 16'h00C3}, {3'b100, 8'h31, 16'h0077},
    {3'b111, 8'h30, 16'h773C}, {3'b010, 8'h44, 16'hBEEF}, {3'b101, 8'h45, 16'h00BE}};

  hpp_port uut (
    .mclk                 (mclk),
    .nrst                 (nrst),
    .port_select          (port_select),
    .mode_pin             (mode_pin),
    .bit_order_select     (bit_order_select),
    .bus_width_16         (bus_width_16),
    .serial_clk           (serial_clk),
    .serial_chip_select_n (serial_chip_select_n),
    .serial_in            (serial_in),
    .receive_frame_pulse  (receive_frame_pulse),
    .transmit_frame_pulse (transmit_frame_pulse),
    .serial_out_o         (serial_out_o),
    .serial_out_oe_n      (serial_out_oe_n),
    .host_port_clock      (host_port_clock),
    .chip_select_n        (chip_select_n),
    .addr                 (addr),
    .data_i               (data_i),
    .data_o               (data_o),
    .data_oe_n            (data_oe_n),
    .wr_n_rw              (wr_n_rw),
    .rd_n_ds_n            (rd_n_ds_n),
    .ready_o              (ready_o),
    .ready_oe_n           (ready_oe_n)
  );
  hpp_host_model u_host (
    .mclk                 (mclk),
    .serial_clk           (serial_clk),
    .serial_chip_select_n (serial_chip_select_n),
    .serial_in            (serial_in),
    .receive_frame_pulse  (receive_frame_pulse),
    .transmit_frame_pulse (transmit_frame_pulse),
    .serial_out_o         (serial_out_o),
    .serial_out_oe_n      (serial_out_oe_n),
    .host_port_clock      (host_port_clock),
    .chip_select_n        (chip_select_n),
    .addr                 (addr),
    .data_i               (data_i),
    .wr_n_rw              (wr_n_rw),
    .rd_n_ds_n            (rd_n_ds_n),
    .data_o               (data_o),
    .data_oe_n            (data_oe_n),
    .ready_o              (ready_o),
    .ready_oe_n           (ready_oe_n)
  );

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared=%0d mismatches=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Whole plan needs about 46 us
  initial begin
    #300us;
    err_total++;
    tally_and_finish();
  end

  initial begin
    {nrst, port_select, mode_pin, bit_order_select, bus_width_16} = 5'h00;
    repeat (8) @(posedge mclk);
    #1 chk({13'h0, serial_out_oe_n, data_oe_n, ready_oe_n}, 16'h0007);
    nrst = 1'b1;
    repeat (4) @(posedge mclk);
    // Ordinary microport accesses, both styles and widths
    foreach (rows[i]) begin
      @(posedge mclk) #1 {mode_pin, bus_width_16} = rows[i][26:25];
      u_host.mp(rows[i][26], rows[i][24], rows[i][23:16], rows[i][15:0], q);
      if (rows[i][24]) chk(rows[i][25] ? q : {8'h00, q[7:0]}, rows[i][15:0]);
    end
    // Framed serial write then read, each bit order, after an aborted one-byte frame
    for (int o = 0; o < 2; o++) begin
      @(posedge mclk) #1 {port_select, mode_pin, bit_order_select} = {2'b11, o[0]};
      a = o ? 8'h62 : 8'h40;
      u_host.sel(1'b0);
      u_host.put_byte(8'h7F, o[0]);
      u_host.sel(1'b1);
      u_host.sel(1'b0);
      u_host.put_byte(a, o[0]);
      u_host.put_byte(8'h03, o[0]);
      foreach (sd[j]) u_host.put_byte(sd[j], o[0]);
      u_host.sel(1'b1);
      u_host.sel(1'b0);
      u_host.put_byte(a, o[0]);
      u_host.put_byte(8'h83, o[0]);
      foreach (sd[j]) begin
        u_host.get_byte(o[0], b);
        chk({8'h00, b}, {8'h00, sd[j]});
      end
      u_host.sel(1'b1);
      // Last byte seen through the microport proves the address stepping
      @(posedge mclk) #1 {port_select, mode_pin} = 2'b00;
      u_host.mp(1'b0, 1'b1, o ? a - 8'h02 : a + 8'h02, 16'h0000, q);
      chk({8'h00, q[7:0]}, {8'h00, sd[2]});
    end
    // Serial port in the unbuilt SPI style stays silent, so the pull-up is read
    @(posedge mclk) #1 {port_select, mode_pin} = 2'b10;
    u_host.sel(1'b0);
    u_host.put_byte(8'h40, 1'b0);
    u_host.put_byte(8'h81, 1'b0);
    u_host.get_byte(1'b0, b);
    u_host.sel(1'b1);
    chk({8'h00, b}, 16'h00FF);
    chk(16'(u_host.tmo), 16'h0000);
    tally_and_finish();
  end
endmodule // hpp_port_test

// ---- hpp_regmem.sv ----
// Byte-wide register memory with registered read data, one write port and two read ports
module hpp_regmem (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Write port
  input  wire logic       we,
  input  wire logic [7:0] waddr,
  input  wire logic [7:0] wdata,
  // Read port A
  input  wire logic [7:0] raddr_a,
  output logic      [7:0] rdata_a,
  // Read port B
  input  wire logic [7:0] raddr_b,
  output logic      [7:0] rdata_b
);
  logic [7:0] mem [hpp_pkg::MEM_DEPTH];

  // Storage; no reset so it maps to RAM
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered reads
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdata_a <= hpp_pkg::BYTE_RST;
      rdata_b <= hpp_pkg::BYTE_RST;
    end else begin
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
    end
  end
endmodule // hpp_regmem
